/* shared/tmon_pkg.sv */
// Shared constants, types and carriers of the temperature monitor register bank
`default_nettype none

package tmon_pkg;

   // ==========================================================
   // Register offsets (read address / write address)
   // ==========================================================
   localparam logic [7:0] OFS_LOCAL_TEMP_RESULT     = 8'h00;
   localparam logic [7:0] OFS_REMOTE_TEMP_RESULT_HI = 8'h01;
   localparam logic [7:0] OFS_STATUS                = 8'h02;
   localparam logic [7:0] RD_LOCAL_HIGH_LIMIT       = 8'h05;
   localparam logic [7:0] RD_LOCAL_LOW_LIMIT        = 8'h06;
   localparam logic [7:0] RD_REMOTE_HIGH_LIMIT_HI   = 8'h07;
   localparam logic [7:0] RD_REMOTE_LOW_LIMIT_HI    = 8'h08;
   localparam logic [7:0] WR_LOCAL_HIGH_LIMIT       = 8'h0b;
   localparam logic [7:0] WR_LOCAL_LOW_LIMIT        = 8'h0c;
   localparam logic [7:0] WR_REMOTE_HIGH_LIMIT_HI   = 8'h0d;
   localparam logic [7:0] WR_REMOTE_LOW_LIMIT_HI    = 8'h0e;
   localparam logic [7:0] OFS_REMOTE_TEMP_RESULT_LO = 8'h10;
   localparam logic [7:0] OFS_REMOTE_OFFSET_HI      = 8'h11;
   localparam logic [7:0] OFS_REMOTE_OFFSET_LO      = 8'h12;
   localparam logic [7:0] OFS_REMOTE_HIGH_LIMIT_LO  = 8'h13;
   localparam logic [7:0] OFS_REMOTE_LOW_LIMIT_LO   = 8'h14;
   localparam logic [7:0] OFS_REMOTE_SHUTDOWN_LIMIT = 8'h19;
   localparam logic [7:0] OFS_LOCAL_SHUTDOWN_LIMIT  = 8'h20;
   localparam logic [7:0] OFS_SHUTDOWN_HYSTERESIS   = 8'h21;
   localparam logic [7:0] OFS_FAULT_CTRL            = 8'h22;

   // ==========================================================
   // Reset values and field positions
   // ==========================================================
   localparam logic [7:0] RST_LIMIT_85    = 8'h55;
   localparam logic [7:0] RST_ZERO        = 8'h00;
   localparam logic [7:0] RST_HYSTERESIS  = 8'h0a;
   localparam logic [7:0] RD_UNMAPPED     = 8'hff;
   localparam int         CTRL_SCL_TO_BIT = 7;
   localparam int         CTRL_SDA_TO_BIT = 6;
   localparam int         CTRL_FQ_MSB     = 3;
   localparam int         CTRL_FQ_LSB     = 1;
   localparam logic [2:0] FAULT_CNT_MAX   = 3'd4;

   // ==========================================================
   // Timing
   // ==========================================================
   localparam int CLK_PERIOD_NS = 10;
   localparam int BUS_TIMEOUT_MS = 25;
   localparam int BUS_TIMEOUT_CYC = BUS_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;

   // ==========================================================
   // Types
   // ==========================================================
   typedef enum logic [2:0] {
      PH_IDLE  = 3'b000,
      PH_ADDR  = 3'b001,
      PH_AACK  = 3'b010,
      PH_WDATA = 3'b011,
      PH_WACK  = 3'b100,
      PH_RDATA = 3'b101,
      PH_RACK  = 3'b110
   } phase_e;

   // One register access from the serial interface, one-cycle strobes
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_acc_s;

endpackage : tmon_pkg

`default_nettype wire

/* src/smbus_target.sv */
// Two-wire serial target: byte pointer, register writes and reads, line timeouts
`default_nettype none

module smbus_target
#(
   parameter logic [6:0] BUS_ADDR    = 7'h40, // arbitrary value
   parameter int         TIMEOUT_CYC = tmon_pkg::BUS_TIMEOUT_CYC
)
(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   // Bus pins
   input  wire logic              scl,
   input  wire logic              sda_in,
   output var  logic              sda_oe,
   // Timeout enables
   input  wire logic              scl_to_en,
   input  wire logic              sda_to_en,
   // Register side
   input  wire logic [7:0]        rdata,
   output var  tmon_pkg::reg_acc_s acc
);
   import tmon_pkg::*;

   localparam logic [21:0] TO_LIM = 22'(TIMEOUT_CYC);

   typedef struct packed {
      logic        scl_s1, scl_s2, scl_d;
      logic        sda_s1, sda_s2, sda_d;
      phase_e      phase;
      logic [3:0]  bitcnt;
      logic [7:0]  shreg;
      logic        rw, first, nack, oe;
      logic [7:0]  ptr;
      logic [21:0] scl_cnt, sda_cnt;
      reg_acc_s    acc;
   } bus_s;

   bus_s st;
   bus_s n;
   logic rise, fall, start, stop, tmo;

   // ==========================================================
   // Next state
   // ==========================================================
   always_comb
   begin
      n = st;
      n.scl_s1 = scl;
      n.scl_s2 = st.scl_s1;
      n.scl_d  = st.scl_s2;
      n.sda_s1 = sda_in;
      n.sda_s2 = st.sda_s1;
      n.sda_d  = st.sda_s2;
      n.acc.wr = 1'b0;
      n.acc.rd = 1'b0;
      rise  = st.scl_s2 && !st.scl_d;
      fall  = !st.scl_s2 && st.scl_d;
      start = st.scl_s2 && st.scl_d && st.sda_d && !st.sda_s2;
      stop  = st.scl_s2 && st.scl_d && !st.sda_d && st.sda_s2;
      // Low-time counters stop at the limit so each timeout fires once
      n.scl_cnt = (scl_to_en && !st.scl_s2) ? st.scl_cnt + 22'(st.scl_cnt != TO_LIM) : '0;
      n.sda_cnt = (sda_to_en && !st.sda_s2) ? st.sda_cnt + 22'(st.sda_cnt != TO_LIM) : '0;
      tmo = (n.scl_cnt == TO_LIM && st.scl_cnt != TO_LIM) ||
            (n.sda_cnt == TO_LIM && st.sda_cnt != TO_LIM); // RQ14
      if (tmo || stop)
      begin
         n.phase = PH_IDLE; // RQ14
         n.oe    = 1'b0;
      end
      else if (start)
      begin
         n.phase  = PH_ADDR;
         n.bitcnt = '0;
         n.first  = 1'b1;
         n.oe     = 1'b0;
      end
      else if (rise)
      begin
         case (st.phase)
            PH_ADDR, PH_WDATA:
            begin
               n.shreg  = {st.shreg[6:0], st.sda_s2};
               n.bitcnt = st.bitcnt + 4'd1;
            end
            PH_RDATA: n.bitcnt = st.bitcnt + 4'd1;
            PH_RACK:  n.nack = st.sda_s2;
            default:  ;
         endcase
      end
      else if (fall)
      begin
         case (st.phase)
            PH_ADDR:
               if (st.bitcnt == 4'd8)
               begin
                  // Only our own address is acknowledged
                  n.phase = (st.shreg[7:1] == BUS_ADDR) ? PH_AACK : PH_IDLE;
                  n.oe    = (st.shreg[7:1] == BUS_ADDR);
                  n.rw    = st.shreg[0];
               end
            PH_AACK, PH_RACK:
            begin
               n.bitcnt = '0;
               if (st.phase == PH_RACK && st.nack)
               begin
                  n.phase = PH_IDLE;
                  n.oe    = 1'b0;
               end
               else if (st.rw)
               begin
                  // Repeated reads return the same register, no increment
                  n.phase    = PH_RDATA;
                  n.shreg    = rdata;
                  n.oe       = !rdata[7];
                  n.acc.rd   = 1'b1;
                  n.acc.addr = st.ptr;
               end
               else
               begin
                  n.phase = PH_WDATA;
                  n.oe    = 1'b0;
               end
            end
            PH_WDATA:
               if (st.bitcnt == 4'd8)
               begin
                  n.phase = PH_WACK;
                  n.oe    = 1'b1;
                  if (st.first)
                     n.ptr = st.shreg;
                  else
                  begin
                     n.acc.wr    = 1'b1;
                     n.acc.addr  = st.ptr;
                     n.acc.wdata = st.shreg;
                  end
               end
            PH_WACK:
            begin
               n.phase  = PH_WDATA;
               n.oe     = 1'b0;
               n.bitcnt = '0;
               n.first  = 1'b0;
            end
            PH_RDATA:
               if (st.bitcnt == 4'd8)
               begin
                  n.phase = PH_RACK; // Release for the host's acknowledge
                  n.oe    = 1'b0;
               end
               else
               begin
                  n.shreg = {st.shreg[6:0], 1'b0};
                  n.oe    = !st.shreg[6];
               end
            default: ;
         endcase
      end
   end

   // ==========================================================
   // State register
   // ==========================================================
   always_ff @(posedge clk)
   begin
      if (rst)
         st <= '{scl_s1: 1'b1, scl_s2: 1'b1, scl_d: 1'b1, sda_s1: 1'b1,
                 sda_s2: 1'b1, sda_d: 1'b1, phase: PH_IDLE, default: '0};
      else
         st <= n;
   end

   assign sda_oe = st.oe;
   assign acc    = st.acc;

   a_timeout_release : assert property (@(posedge clk) disable iff (rst)
      (scl_to_en && st.scl_cnt == TO_LIM - 22'd1 && !st.scl_s2)
      |=> (!sda_oe && st.phase == PH_IDLE)) else $error("timeout did not free the bus"); // RQ14
   c_timeout : cover property (@(posedge clk) disable iff (rst) $rose(st.scl_cnt == TO_LIM));

endmodule : smbus_target

`default_nettype wire

/* src/thermal_monitor_limit_regs.sv */
// Temperature monitor register bank with limits, fault queue and bus timeouts
// Function
// [RQ1] Control register at 0x22, read and write
// [RQ2] Bit 7 enables clock-line timeout, off at reset
// [RQ3] Bit 6 enables data-line timeout, off at reset
// [RQ4] Alert needs 1-4 consecutive faults, bit0 ignored
// [RQ5] Remote result 0x01/0x10, read-only, reset zero
// [RQ6] Local high limit read 05, write 0B
// [RQ7] Local low limit read 06, write 0C
// [RQ8] Remote high limit byte read 07, write 0D
// [RQ9] Remote low limit byte read 08, write 0E
// [RQ10] Remote high fraction at 13, reset zero
// [RQ11] Remote low fraction at 14, reset zero
// [RQ12] Offset bytes at 11 and 12, reset zero
// [RQ13] Fault flags sticky until status read
// [RQ14] Held-low line times out, bus released
`default_nettype none

module thermal_monitor_limit_regs
#(
   parameter logic [6:0] BUS_ADDR    = 7'h40, // arbitrary value
   parameter int         TIMEOUT_CYC = tmon_pkg::BUS_TIMEOUT_CYC
)
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // Serial bus pins
   input  wire logic        scl,
   input  wire logic        sda_in,
   output var  logic        sda_out,
   output var  logic        sda_oe,
   // Conversion results
   input  wire logic        meas_valid,
   input  wire logic [7:0]  meas_local,
   input  wire logic [15:0] meas_remote,
   input  wire logic        meas_open,
   // Alarm and calibration outputs
   output var  logic        alert_n,
   output var  logic        overtemp_shutdown_output,
   output var  logic [15:0] remote_offset
);
   import tmon_pkg::*;

   typedef struct packed {
      logic [7:0] local_temp_result;
      logic [7:0] remote_temp_result_hi;
      logic [7:0] remote_temp_result_lo;
      logic [7:0] local_high_limit;
      logic [7:0] local_low_limit;
      logic [7:0] remote_high_limit_hi;
      logic [7:0] remote_low_limit_hi;
      logic [7:0] remote_high_limit_lo;
      logic [7:0] remote_low_limit_lo;
      logic [7:0] remote_offset_hi;
      logic [7:0] remote_offset_lo;
      logic [7:0] remote_shutdown_limit;
      logic [7:0] local_shutdown_limit;
      logic [7:0] shutdown_hysteresis;
      logic       scl_to_en;
      logic       sda_to_en;
      logic [2:0] fault_queue;
      logic [4:0] flags;     // local high, local low, remote high, remote low, open
      logic       local_sd;
      logic       remote_sd;
      logic [2:0] fault_cnt;
      logic       alert_n;
      logic       shutdown;
   } bank_s;

   localparam bank_s BANK_RST = '{
      local_high_limit:      RST_LIMIT_85,
      remote_high_limit_hi:  RST_LIMIT_85,
      remote_shutdown_limit: RST_LIMIT_85,
      local_shutdown_limit:  RST_LIMIT_85,
      shutdown_hysteresis:   RST_HYSTERESIS,
      alert_n:               1'b1,
      default:               '0
   };

   bank_s      st;
   bank_s      n;
   reg_acc_s   acc;
   logic [7:0] rdata;
   logic [7:0] ptr_q;
   logic [4:0] set_flags;
   logic       any_fault;

   // ==========================================================
   // Helpers
   // ==========================================================
   // Ones in the queue code plus one: 000->1, 001->2, 011->3, 111->4
   function automatic logic [2:0] need_count(input logic [2:0] q);
      return {2'b00, q[0]} + {2'b00, q[1]} + {2'b00, q[2]} + 3'd1;
   endfunction : need_count

   // Release point of a shutdown output: below limit by the hysteresis
   function automatic logic released(input logic [7:0] t, input logic [7:0] lim,
                                     input logic [7:0] h);
      return ({1'b0, t} + {1'b0, h}) < {1'b0, lim};
   endfunction : released

   function automatic logic [7:0] read_mux(input bank_s s, input logic [7:0] a);
      case (a)
         OFS_LOCAL_TEMP_RESULT:     return s.local_temp_result;
         OFS_REMOTE_TEMP_RESULT_HI: return s.remote_temp_result_hi; // RQ5
         OFS_REMOTE_TEMP_RESULT_LO: return s.remote_temp_result_lo; // RQ5
         OFS_STATUS:                return {1'b0, s.flags, s.remote_sd, s.local_sd};
         RD_LOCAL_HIGH_LIMIT:       return s.local_high_limit; // RQ6
         RD_LOCAL_LOW_LIMIT:        return s.local_low_limit; // RQ7
         RD_REMOTE_HIGH_LIMIT_HI:   return s.remote_high_limit_hi; // RQ8
         RD_REMOTE_LOW_LIMIT_HI:    return s.remote_low_limit_hi; // RQ9
         OFS_REMOTE_HIGH_LIMIT_LO:  return s.remote_high_limit_lo; // RQ10
         OFS_REMOTE_LOW_LIMIT_LO:   return s.remote_low_limit_lo; // RQ11
         OFS_REMOTE_OFFSET_HI:      return s.remote_offset_hi; // RQ12
         OFS_REMOTE_OFFSET_LO:      return s.remote_offset_lo; // RQ12
         OFS_REMOTE_SHUTDOWN_LIMIT: return s.remote_shutdown_limit;
         OFS_LOCAL_SHUTDOWN_LIMIT:  return s.local_shutdown_limit;
         OFS_SHUTDOWN_HYSTERESIS:   return s.shutdown_hysteresis;
         OFS_FAULT_CTRL:            return {s.scl_to_en, s.sda_to_en, 2'b00, s.fault_queue, 1'b0}; // RQ1
         default:                   return RD_UNMAPPED;
      endcase
   endfunction : read_mux

   // ==========================================================
   // Serial interface
   // ==========================================================
   smbus_target #(
      .BUS_ADDR    (BUS_ADDR),
      .TIMEOUT_CYC (TIMEOUT_CYC)
   ) u_bus (
      .clk       (clk),
      .rst       (rst),
      .scl       (scl),
      .sda_in    (sda_in),
      .sda_oe    (sda_oe),
      .scl_to_en (st.scl_to_en), // RQ2
      .sda_to_en (st.sda_to_en), // RQ3
      .rdata     (rdata),
      .acc       (acc)
   );

   // Read data follows the pointer held inside the serial interface
   assign ptr_q = u_bus.st.ptr;
   assign rdata = read_mux(st, ptr_q);

   // ==========================================================
   // Register writes, measurements, flags and alarms
   // ==========================================================
   always_comb
   begin
      n         = st;
      set_flags = '0;
      any_fault = 1'b0;
      // Result registers have no write address, so writes miss them
      if (acc.wr)
      begin
         case (acc.addr)
            WR_LOCAL_HIGH_LIMIT:       n.local_high_limit = acc.wdata; // RQ6
            WR_LOCAL_LOW_LIMIT:        n.local_low_limit = acc.wdata; // RQ7
            WR_REMOTE_HIGH_LIMIT_HI:   n.remote_high_limit_hi = acc.wdata; // RQ8
            WR_REMOTE_LOW_LIMIT_HI:    n.remote_low_limit_hi = acc.wdata; // RQ9
            OFS_REMOTE_HIGH_LIMIT_LO:  n.remote_high_limit_lo = acc.wdata; // RQ10
            OFS_REMOTE_LOW_LIMIT_LO:   n.remote_low_limit_lo = acc.wdata; // RQ11
            OFS_REMOTE_OFFSET_HI:      n.remote_offset_hi = acc.wdata; // RQ12
            OFS_REMOTE_OFFSET_LO:      n.remote_offset_lo = acc.wdata; // RQ12
            OFS_REMOTE_SHUTDOWN_LIMIT: n.remote_shutdown_limit = acc.wdata;
            OFS_LOCAL_SHUTDOWN_LIMIT:  n.local_shutdown_limit = acc.wdata;
            OFS_SHUTDOWN_HYSTERESIS:   n.shutdown_hysteresis = acc.wdata;
            OFS_FAULT_CTRL:
            begin
               n.scl_to_en   = acc.wdata[CTRL_SCL_TO_BIT]; // RQ1 RQ2
               n.sda_to_en   = acc.wdata[CTRL_SDA_TO_BIT]; // RQ3
               n.fault_queue = acc.wdata[CTRL_FQ_MSB:CTRL_FQ_LSB]; // RQ4
            end
            default: ;
         endcase
      end
      // Each finished conversion is checked against the limits in force
      if (meas_valid)
      begin
         n.local_temp_result     = meas_local;
         n.remote_temp_result_hi = meas_remote[15:8]; // RQ5
         n.remote_temp_result_lo = meas_remote[7:0]; // RQ5
         set_flags[4] = meas_local > st.local_high_limit;
         set_flags[3] = meas_local < st.local_low_limit;
         set_flags[2] = meas_remote > {st.remote_high_limit_hi, st.remote_high_limit_lo};
         set_flags[1] = meas_remote < {st.remote_low_limit_hi, st.remote_low_limit_lo};
         set_flags[0] = meas_open;
         any_fault    = |set_flags;
         // Count saturates so a long fault never wraps back under the queue
         if (!any_fault)
            n.fault_cnt = '0;
         else if (st.fault_cnt != FAULT_CNT_MAX)
            n.fault_cnt = st.fault_cnt + 3'd1;
         n.alert_n = !(n.fault_cnt >= need_count(st.fault_queue)); // RQ4
         if (meas_local >= st.local_shutdown_limit)
            n.local_sd = 1'b1;
         else if (released(meas_local, st.local_shutdown_limit, st.shutdown_hysteresis))
            n.local_sd = 1'b0;
         if (meas_remote[15:8] >= st.remote_shutdown_limit)
            n.remote_sd = 1'b1;
         else if (released(meas_remote[15:8], st.remote_shutdown_limit, st.shutdown_hysteresis))
            n.remote_sd = 1'b0;
      end
      n.shutdown = n.local_sd || n.remote_sd;
      // Status read clears the sticky flags; a fault in that cycle survives
      if (acc.rd && acc.addr == OFS_STATUS)
         n.flags = '0; // RQ13
      n.flags = n.flags | set_flags; // RQ13
   end

   // ==========================================================
   // State register
   // ==========================================================
   always_ff @(posedge clk)
   begin
      if (rst)
         st <= BANK_RST;
      else
         st <= n;
   end

   // Pin data is always low; only the enable moves (open drain)
   assign sda_out                  = 1'b0;
   assign alert_n                  = st.alert_n;
   assign overtemp_shutdown_output = st.shutdown;
   assign remote_offset            = {st.remote_offset_hi, st.remote_offset_lo};

   // ==========================================================
   // Checks
   // ==========================================================
   a_ctrl_readback : assert property (@(posedge clk) disable iff (rst)
      (acc.wr && acc.addr == OFS_FAULT_CTRL) |=>
      read_mux(st, OFS_FAULT_CTRL) == ($past(acc.wdata) & 8'hce)) else $error("control readback wrong"); // RQ1
   a_scl_to_bit : assert property (@(posedge clk)
      $fell(rst) |-> !st.scl_to_en && !st.sda_to_en) else $error("timeout enable not off after reset"); // RQ2
   a_sda_to_bit : assert property (@(posedge clk) disable iff (rst)
      (acc.wr && acc.addr == OFS_FAULT_CTRL) |=> st.sda_to_en == $past(acc.wdata[6]))
      else $error("data timeout enable wrong"); // RQ3
   a_fault_gate : assert property (@(posedge clk) disable iff (rst)
      (meas_valid && n.fault_cnt < need_count(st.fault_queue)) |=> alert_n) else $error("alert too early"); // RQ4
   a_result_ro : assert property (@(posedge clk) disable iff (rst)
      (acc.wr && !meas_valid) |=> $stable(st.remote_temp_result_hi) && $stable(st.remote_temp_result_lo))
      else $error("result changed by write"); // RQ5
   a_local_high_wr : assert property (@(posedge clk) disable iff (rst)
      (acc.wr && acc.addr == WR_LOCAL_HIGH_LIMIT) |=>
      read_mux(st, RD_LOCAL_HIGH_LIMIT) == $past(acc.wdata)) else $error("local high limit not written"); // RQ6
   a_local_low_wr : assert property (@(posedge clk) disable iff (rst)
      (acc.wr && acc.addr == WR_LOCAL_LOW_LIMIT) |=>
      read_mux(st, RD_LOCAL_LOW_LIMIT) == $past(acc.wdata)) else $error("local low limit not written"); // RQ7
   a_remote_hi_wr : assert property (@(posedge clk) disable iff (rst)
      (acc.wr && acc.addr == WR_REMOTE_HIGH_LIMIT_HI) |=>
      st.remote_high_limit_hi == $past(acc.wdata)) else $error("remote high limit not written"); // RQ8
   a_flag_sticky : assert property (@(posedge clk) disable iff (rst)
      (st.flags != '0 && !(acc.rd && acc.addr == OFS_STATUS)) |=> (st.flags & $past(st.flags)) == $past(st.flags))
      else $error("fault flag lost"); // RQ13
   c_status_read : cover property (@(posedge clk) disable iff (rst) acc.rd && acc.addr == OFS_STATUS && st.flags != '0);
   c_alert : cover property (@(posedge clk) disable iff (rst) $fell(alert_n) && st.fault_queue == 3'b111);
   c_shutdown : cover property (@(posedge clk) disable iff (rst) $rose(overtemp_shutdown_output));

endmodule : thermal_monitor_limit_regs

`default_nettype wire

/* verification/smbus_host_model.sv */
// Two-wire bus host model: master with driven clock, open-drain data and register access tasks
`default_nettype none

module smbus_host_model
#(
   parameter logic [6:0] ADDR = 7'h40, // arbitrary value
   parameter int         Q    = 4
)
(
   // Clock
   input  wire logic clk,
   // Bus wires
   input  wire logic sda_oe,
   output var  logic scl,
   output wire logic sda
);
   timeunit 1ns;
   timeprecision 1ns;
   logic host_low = 1'b0;
   // Pull-up: a released line reads high
   assign sda = !(sda_oe || host_low);
   initial scl = 1'b1;

   // ==========================================================
   // Line phases, each held Q+1 clocks so the synchroniser keeps up
   // ==========================================================
   task automatic lines(input logic c, input logic d);
      @(posedge clk);
      scl <= c;
      host_low <= !d;
      repeat (Q) @(posedge clk);
   endtask : lines

   task automatic start();
      lines(1'b0, 1'b1);
      lines(1'b1, 1'b1);
      lines(1'b1, 1'b0);
   endtask : start

   // Eight bits plus a released ninth; lim 0 stops before the ninth
   task automatic xfer(input logic [7:0] o, input int lim, output logic [8:0] i);
      i = '0;
      for (int k = 7; k >= lim; k--)
      begin
         lines(1'b0, k < 0 ? 1'b1 : o[k[2:0]]);
         lines(1'b1, k < 0 ? 1'b1 : o[k[2:0]]);
         i = {i[7:0], sda};
      end
   endtask : xfer

   // ==========================================================
   // Pointer write, then a data write or a restarted read (NACK)
   // ==========================================================
   task automatic acc(input logic rnw, input logic [7:0] p, input logic [7:0] d, output logic [7:0] q);
      logic [8:0] a;
      start();
      xfer({ADDR, 1'b0}, -1, a);
      xfer(p, -1, a);
      if (rnw)
      begin
         start();
         xfer({ADDR, 1'b1}, -1, a);
      end
      xfer(rnw ? 8'hff : d, -1, a);
      q = a[8:1];
      lines(1'b0, 1'b0);
      lines(1'b1, 1'b0);
      lines(1'b1, 1'b1);
   endtask : acc

   // Clock held low through the address acknowledge; reports the pull
   task automatic stall(output logic held);
      logic [8:0] a;
      start();
      xfer({ADDR, 1'b0}, 0, a);
      lines(1'b0, 1'b1);
      repeat (250) @(posedge clk);
      held = sda_oe;
      lines(1'b1, 1'b1);
      lines(1'b0, 1'b0);
      lines(1'b1, 1'b0);
      lines(1'b1, 1'b1);
   endtask : stall
endmodule : smbus_host_model

`default_nettype wire

/* verification/testbench.sv */
// Self-checking bench for the temperature monitor register bank
`default_nettype none

module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import tmon_pkg::*;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        mv  = 1'b0;
   logic [7:0]  ml  = 8'h40;
   wire         scl, sda, oe, alert_n, shut;
   wire [15:0]  offs;
   logic [7:0]  q;
   int          failures = 0;
   int          num_checks = 0;
   int          cyc = 0;
   // Read addr, write addr, value before, value written, value after
   logic [39:0] rows [16] = '{40'h00_00_00_3c_00, 40'h01_01_00_3c_00, 40'h10_10_00_3c_00,
      40'h05_0b_55_3c_3c, 40'h05_05_3c_99_3c, 40'h06_0c_00_11_11, 40'h07_0d_55_66_66,
      40'h08_0e_00_22_22, 40'h13_13_00_c0_c0, 40'h14_14_00_40_40, 40'h11_11_00_12_12,
      40'h12_12_00_80_80, 40'h19_19_55_70_70, 40'h20_20_55_71_71, 40'h21_21_0a_05_05,
      40'h22_22_00_ff_ce};
   logic [7:0]  codes [5] = '{8'h00, 8'h01, 8'h02, 8'h06, 8'h0e};
   int          need [5] = '{1, 1, 2, 3, 4};
   logic [7:0]  tmo [3] = '{8'h00, 8'h80, 8'h40};

   thermal_monitor_limit_regs #(.TIMEOUT_CYC(200)) dut
   (
      .clk(clk), .rst(rst), .scl(scl), .sda_in(sda), .sda_out(), .sda_oe(oe), .meas_valid(mv),
      .meas_local(ml), .meas_remote(16'h3000), .meas_open(1'b0), .alert_n(alert_n),
      .overtemp_shutdown_output(shut), .remote_offset(offs)
   );
   smbus_host_model host (.clk(clk), .sda_oe(oe), .scl(scl), .sda(sda));

   // ==========================================================
   // Helpers
   // ==========================================================
   task automatic chk8(input logic [7:0] g, input logic [7:0] e);
      num_checks++;
      if (g !== e)
      begin
         failures++;
         $display("[ERR] %0t got %h want %h", $time, g, e);
      end
   endtask : chk8

   task automatic test_done();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : test_done

   // One conversion pulse, then settle past the update edge
   task automatic meas(input logic [7:0] t);
      @(posedge clk);
      mv <= 1'b1;
      ml <= t;
      @(posedge clk);
      mv <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
   endtask : meas

   initial forever #5 clk = ~clk;

   // Hang guard, well above the expected run length
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 60000)
      begin
         failures++;
         test_done();
      end
   end

   // ==========================================================
   // Main sequence
   // ==========================================================
   initial
   begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      foreach (rows[i])
      begin
         host.acc(1'b1, rows[i][39:32], 8'h00, q);
         chk8(q, rows[i][23:16]);
         host.acc(1'b0, rows[i][31:24], rows[i][15:8], q);
         host.acc(1'b1, rows[i][39:32], 8'h00, q);
         chk8(q, rows[i][7:0]);
      end
      chk8(offs[15:8], 8'h12);
      chk8(offs[7:0], 8'h80);
      host.acc(1'b1, 8'h30, 8'h00, q);
      chk8(q, 8'hff);
      // Fault queue: alert only on the last of the needed run
      foreach (codes[i])
      begin
         host.acc(1'b0, OFS_FAULT_CTRL, codes[i], q);
         meas(8'h20); // Clean reading between the written limits clears the run
         for (int k = 1; k <= need[i]; k++)
         begin
            meas(8'h50);
            chk8({7'h0, alert_n}, {7'h0, k < need[i]});
         end
      end
      host.acc(1'b1, OFS_STATUS, 8'h00, q);
      chk8(q, 8'h40);
      host.acc(1'b1, OFS_STATUS, 8'h00, q);
      chk8(q, 8'h00);
      meas(8'h80);
      chk8({7'h0, shut}, 8'h01);
      // Stuck clock: the acknowledge pull is dropped only when a timeout is on
      foreach (tmo[i])
      begin
         host.acc(1'b0, OFS_FAULT_CTRL, tmo[i], q);
         host.stall(q[0]);
         chk8({7'h0, q[0]}, {7'h0, tmo[i] == 8'h00});
      end
      test_done();
   end
endmodule : testbench

`default_nettype wire
